// ==== rtl/cfg_wdt_consts.svh ====
// constants for the configuration port and watchdog block
// assumes byte i/o cycles decoded on a 16-bit port address
//
// Notes on behaviour
// - the index port sits at 2e and the data port at 2f; index selects the register, data moves it.
// - configuration mode is entered only after two back-to-back writes of 87 to 2e or 4e.
// - the index port shares the unlock address and the data port is one above it.
// - global registers below 30 are reached without any logical device selected.
// - after selection, the index names a register of that device and data acts on it.
// - writing aa to the unlock port leaves configuration mode.
// - after leaving, normal operation resumes and a fresh unlock is accepted.
// - watchdog registers belong to logical device 8.
// - bit 08h of watchdog register f5 selects the unit; cleared means seconds.
// - a nonzero write to watchdog register f6 loads the interval and starts counting at once.
`ifndef CFG_WDT_CONSTS_SVH
`define CFG_WDT_CONSTS_SVH
`define PORT_PRIMARY     16'h002e
`define PORT_ALTERNATE   16'h004e
`define UNLOCK_KEY       8'h87
`define LOCK_KEY         8'haa
`define REG_LDN          8'h07
`define GLOBAL_LIMIT     8'h30
`define LDN_WATCHDOG     8'h08
`define REG_WDT_CTRL     8'hf5
`define REG_WDT_COUNT    8'hf6
`define WDT_UNIT_BIT     3
`define CLK_HZ           32'd50000000
`define SEC_CYCLES       (`CLK_HZ)
`define MIN_CYCLES       (32'd60 * `CLK_HZ)
`endif

// ==== rtl/cfg_wdt_pkg.sv ====
// types for the configuration port and watchdog block
// assumes the constants header is included by users
package cfg_wdt_pkg;
   typedef enum logic [1:0] {
      lock_idle  = 2'b00,
      lock_half  = 2'b01,
      lock_open  = 2'b10
   } lock_state_t;

   typedef struct packed {
      lock_state_t lock;
      logic [7:0]  index;
      logic [7:0]  ldn;
      logic [7:0]  ctrl;
      logic [7:0]  count;
      logic        running;
      logic        timeout;
      logic [31:0] tick_cnt;
      logic [7:0]  rdata;
   } state_t;
endpackage

// ==== rtl/config_port_watchdog.sv ====
// configuration port pair with a watchdog logical device
// assumes one i/o cycle per strobe, synchronous to clk_sys_i
`timescale 1ns/1ns
`include "cfg_wdt_consts.svh"
module config_port_watchdog #(
   parameter logic [31:0] SEC_CYCLES = `SEC_CYCLES,
   parameter logic [31:0] MIN_CYCLES = `MIN_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic [15:0] io_addr_i,
   input  wire logic        io_wr_i,
   input  wire logic        io_rd_i,
   input  wire logic [7:0]  io_wdata_i,
   output logic      [7:0]  io_rdata_o,
   output logic             io_hit_o,
   output logic             cfg_mode_o,
   output logic             timeout_o
);
   cfg_wdt_pkg::state_t s;
   cfg_wdt_pkg::state_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic is_base(input logic [15:0] a);
      is_base = (a == `PORT_PRIMARY) || (a == `PORT_ALTERNATE);
   endfunction

   logic index_hit;
   logic data_hit;
   logic wdt_sel;
   logic [31:0] unit_len;
   logic        expire;
   assign index_hit = is_base(io_addr_i);
   assign data_hit  = is_base(io_addr_i - 16'h0001);
   assign wdt_sel   = (s.ldn == `LDN_WATCHDOG) && (s.index >= `GLOBAL_LIMIT);
   assign unit_len  = s.ctrl[`WDT_UNIT_BIT] ? MIN_CYCLES : SEC_CYCLES;
   // expiry in the same cycle as a count write keeps the timeout flag set
   assign expire    = s.running && (s.tick_cnt >= unit_len - 32'h1) && (s.count == 8'h01);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      // unlock state machine
      if (io_wr_i && index_hit) begin
         case (s.lock)
            cfg_wdt_pkg::lock_idle: begin
               if (io_wdata_i == `UNLOCK_KEY) next_s.lock = cfg_wdt_pkg::lock_half;
            end
            cfg_wdt_pkg::lock_half: begin
               next_s.lock = (io_wdata_i == `UNLOCK_KEY) ? cfg_wdt_pkg::lock_open
                                                        : cfg_wdt_pkg::lock_idle;
            end
            cfg_wdt_pkg::lock_open: begin
               if (io_wdata_i == `LOCK_KEY) next_s.lock = cfg_wdt_pkg::lock_idle;
               else next_s.index = io_wdata_i;
            end
            default: next_s.lock = cfg_wdt_pkg::lock_idle;
         endcase
      end else if ((io_wr_i || io_rd_i) && data_hit && s.lock == cfg_wdt_pkg::lock_half) begin
         next_s.lock = cfg_wdt_pkg::lock_idle;
      end
      // watchdog countdown
      if (s.running) begin
         if (s.tick_cnt >= unit_len - 32'h1) begin
            next_s.tick_cnt = 32'h0;
            next_s.count = s.count - 8'h01;
            if (s.count == 8'h01) begin
               next_s.running = 1'b0;
               next_s.timeout = 1'b1;
            end
         end else begin
            next_s.tick_cnt = s.tick_cnt + 32'h1;
         end
      end
      // data port writes
      if (io_wr_i && data_hit && s.lock == cfg_wdt_pkg::lock_open) begin
         if (s.index == `REG_LDN) next_s.ldn = io_wdata_i;
         else if (wdt_sel && s.index == `REG_WDT_CTRL) next_s.ctrl = io_wdata_i;
         else if (wdt_sel && s.index == `REG_WDT_COUNT) begin
            next_s.count    = io_wdata_i;
            next_s.tick_cnt = 32'h0;
            next_s.running  = (io_wdata_i != 8'h00);
            if (!expire) next_s.timeout = 1'b0;
         end
      end
      // data port and index port reads
      next_s.rdata = 8'h00;
      if (data_hit && s.lock == cfg_wdt_pkg::lock_open) begin
         if (s.index == `REG_LDN) next_s.rdata = s.ldn;
         else if (wdt_sel && s.index == `REG_WDT_CTRL) next_s.rdata = s.ctrl;
         else if (wdt_sel && s.index == `REG_WDT_COUNT) next_s.rdata = s.count;
      end else if (index_hit && s.lock == cfg_wdt_pkg::lock_open) begin
         next_s.rdata = s.index;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign io_rdata_o = s.rdata;
   assign io_hit_o   = (index_hit || data_hit) && (s.lock == cfg_wdt_pkg::lock_open);
   assign cfg_mode_o = (s.lock == cfg_wdt_pkg::lock_open);
   assign timeout_o  = s.timeout;
endmodule // config_port_watchdog

// ==== sim/config_port_watchdog_tb.sv ====
// self-checking bench for config_port_watchdog
// assumes io_host and the bound checker are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("mismatch %0t %h %h", $time, a, b); end end
module config_port_watchdog_tb;
   logic clk_sys_i = 1'b0, resetn_i = 1'b0, wr, rd, hit, mode, tmo;
   logic [15:0] addr;
   logic [7:0] wd, rdat, d;
   int failures = 0, n_checks = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   io_host i_io_host (.clk_sys_i(clk_sys_i), .rdata_i(rdat), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wd));
   config_port_watchdog #(.SEC_CYCLES(32'h4), .MIN_CYCLES(32'h8)) i_config_port_watchdog (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
      .io_wdata_i(wd), .io_rdata_o(rdat), .io_hit_o(hit), .cfg_mode_o(mode), .timeout_o(tmo));
   task automatic w(input logic [15:0] a, input logic [7:0] x); i_io_host.wr(a, x); endtask
   task automatic unl(input logic [15:0] a); w(a, 8'h87); w(a, 8'h87); endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_mode;
      `CHK(mode, 1'b0)
      w(16'h002f, 8'h07); `CHK(hit, 1'b0)
      unl(16'h002e); `CHK(mode, 1'b1)
      `CHK(hit, 1'b1)
      w(16'h002e, 8'haa); `CHK(mode, 1'b0)
      unl(16'h004e); w(16'h004e, 8'h07);
      i_io_host.rd(16'h004e, d); `CHK(d, 8'h07)
      w(16'h004e, 8'haa); $display("t_mode done");
   endtask
   task automatic t_wdt;
      unl(16'h002e); w(16'h002e, 8'h07); w(16'h002f, 8'h05);
      w(16'h002e, 8'hf6); i_io_host.rd(16'h002f, d); `CHK(d, 8'h00)
      w(16'h002e, 8'h07); w(16'h002f, 8'h08);
      i_io_host.rd(16'h002f, d); `CHK(d, 8'h08)
      w(16'h002e, 8'hf5); w(16'h002f, 8'h08);
      i_io_host.rd(16'h002f, d); `CHK(d, 8'h08)
      w(16'h002f, d & 8'hf7);
      i_io_host.rd(16'h002f, d); `CHK(d[3], 1'b0)
      w(16'h002e, 8'hf6); w(16'h002f, 8'h03); repeat (8) @(posedge clk_sys_i);
      `CHK(tmo, 1'b0)
      repeat (8) @(posedge clk_sys_i); `CHK(tmo, 1'b1)
      w(16'h002f, 8'h00); `CHK(tmo, 1'b0)
      w(16'h002e, 8'haa); $display("t_wdt done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin repeat (10) @(posedge clk_sys_i); resetn_i <= 1'b1; t_mode; t_wdt; wrap_up; end
   initial begin #100000; failures++; wrap_up; end
endmodule // config_port_watchdog_tb

// ==== sim/cpw_assertions.sv ====
// assertions on the ports of config_port_watchdog
// assumes the bind below and ports decoded on 16 address bits
`timescale 1ns/1ns
module cpw_assertions (
   input wire logic clk_sys_i, input wire logic resetn_i, input wire logic [15:0] io_addr_i,
   input wire logic io_wr_i, input wire logic [7:0] io_wdata_i, input wire logic io_hit_o,
   input wire logic cfg_mode_o, input wire logic timeout_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   wire at2e = io_addr_i == 16'h002e;
   wire at4e = io_addr_i == 16'h004e;
   wire ports = io_addr_i[15:1] == 15'h0017 || io_addr_i[15:1] == 15'h0027;
   wire unl = io_wr_i && io_wdata_i == 8'h87 && (at2e || at4e);
   wire lock = cfg_mode_o && io_wr_i && io_wdata_i == 8'haa;
   sequence s_unl; !cfg_mode_o && unl && at2e ##1 !io_wr_i ##1 unl && at2e; endsequence
   port_hit_a: assert property (io_hit_o == (cfg_mode_o && ports)) else $error("hit");
   mode_enter_a: assert property (s_unl |=> cfg_mode_o) else $error("entry");
   mode_rise_a: assert property ($rose(cfg_mode_o) |-> $past(unl)) else $error("rise");
   mode_stay_a: assert property (!cfg_mode_o && !io_wr_i |=> !cfg_mode_o) else $error("stay");
   lock_2e_a: assert property (lock && at2e |=> !cfg_mode_o) else $error("exit");
   lock_4e_a: assert property (lock && at4e |=> !cfg_mode_o) else $error("exit");
   mode_hold_a: assert property (cfg_mode_o && !io_wr_i |=> cfg_mode_o) else $error("mode");
   timeout_hold_a: assert property (timeout_o && !io_wr_i |=> timeout_o) else $error("tmo");
endmodule // cpw_assertions
bind config_port_watchdog cpw_assertions i_cpw_assertions (.*);

// ==== sim/io_host.sv ====
// host model issuing byte i/o port cycles
// assumes the block samples on rising edges of clk_sys_i
`timescale 1ns/1ns
module io_host (
   input wire logic clk_sys_i, input wire logic [7:0] rdata_i,
   output logic [15:0] addr_o, output logic wr_o, output logic rd_o, output logic [7:0] wdata_o
);
   initial begin addr_o = 16'h0000; wr_o = 1'b0; rd_o = 1'b0; wdata_o = 8'h00; end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i); addr_o <= a; wdata_o <= d; wr_o <= 1'b1;
      @(posedge clk_sys_i); wr_o <= 1'b0; wdata_o <= ~d; #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys_i); addr_o <= a; rd_o <= 1'b1;
      @(posedge clk_sys_i); #1; d = rdata_i;
      @(posedge clk_sys_i); rd_o <= 1'b0; #1;
   endtask
endmodule // io_host
